// ==== hw/hsp_pkg.sv ====
// shared constants of the host serial handshake port
// assumes one core clock; both ends and the link interface import nothing
package hsp_pkg;
  // *****************************************
  // clock and serial timing
  // *****************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_RATE = 38_400;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE; // cycles per bit, rounded down
  // *****************************************
  // buffers
  // *****************************************
  localparam int TXQ_DEPTH = 512; // bytes queued toward the host
  localparam int CMDQ_DEPTH = 32; // host command bytes awaiting the line
  localparam int BYTE_W = 8;
  // *****************************************
  // power control parameter
  // *****************************************
  localparam int PWR_LP_BIT = 7; // set: low power control owns the pins
  localparam logic [7:0] PWR_CTRL_RST = 8'h80;
  // *****************************************
  // output-full report text: "FULL" cr
  // *****************************************
  localparam int ERR_LEN = 5;
  localparam logic [7:0] ERR_TEXT [ERR_LEN] = '{8'h46, 8'h55, 8'h4c, 8'h4c, 8'h0d};
endpackage

// ==== hw/hsp_link_if.sv ====
// link between device end and host end: two uart lines and the handshake pair
// assumes both ends share core_clk; lines are plain one-way logic signals
`timescale 1ns/100ps
`default_nettype none
interface hsp_link_if;
  logic txd_to_host; // device transmit, idle high
  logic txd_to_dev; // host transmit, idle high
  logic irq_req_n; // host interrupt request, active low
  logic busy; // device busy, active high
  modport dev (output txd_to_host, output busy, input txd_to_dev, input irq_req_n);
  modport host (output txd_to_dev, output irq_req_n, input txd_to_host, input busy);
endinterface
`default_nettype wire

// ==== hw/hsp_dev_end.sv ====
// device end of the host serial port: 512-byte transmit queue, uart, handshake
// also holds the fifo leaf reused by the host end; the uart leaves sit in hw/hsp_host_end.sv
// Functional notes
// - formatted message bytes join the transmit queue
// - queue holds 512 bytes, sent bytes free
// - full queue reports output-full error to host
// - error abandons operation; host must re-request
// - host drains link as fast as filled
// - both serial lines idle high
// - matching baud, transmit crossed to receive
// - busy high while processing, low when idle
// - low request line aborts like received character
// - host samples busy before sending commands
// - host holds request low until busy low
// - host raises request before sending command
// - after interrupt, never busy until command
// - unused request line held high by host
// - handshake disabled by power control reset value
// - clearing bit 7 gives pins to handshake
`timescale 1ns/100ps
`default_nettype none

// *****************************************
// fifo
// *****************************************
module hsp_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("hsp_fifo depth must be a power of two of at least 2");
  end
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_q];
  // storage, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  // pointers; sent bytes free their slot at once
  always_ff @(posedge core_clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *****************************************
// device end
// *****************************************
module hsp_dev_end #(
  parameter int DIV = hsp_pkg::BAUD_DIV,
  parameter int TXQ_DEPTH = hsp_pkg::TXQ_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  hsp_link_if.dev link,
  input wire logic msg_valid,
  output logic msg_ready,
  input wire logic [7:0] msg_data,
  input wire logic op_start,
  input wire logic op_done,
  output logic op_abort,
  output logic overflow_err,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire logic pwr_wr,
  input wire logic [7:0] pwr_wdata,
  output logic [7:0] pwr_ctrl
);
  typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_REPORT} hsp_err_st_t;
  hsp_err_st_t st_q;
  logic [2:0] idx_q;
  logic irq_s1_q, irq_s2_q;
  logic proc_q, wait_cmd_q;
  logic hs_en, abort_req, full_hit;
  logic rx_valid;
  logic [7:0] rx_data;
  logic q_in_valid, q_in_ready, q_out_valid, q_out_ready;
  logic [7:0] q_in_data, q_out_data;

  // power control parameter; reset value leaves handshake off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_ctrl <= hsp_pkg::PWR_CTRL_RST;
    end else if (pwr_wr) begin
      pwr_ctrl <= pwr_wdata;
    end
  end
  assign hs_en = ~pwr_ctrl[hsp_pkg::PWR_LP_BIT];

  // request pin from the host, two-stage sync
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
    end else begin
      irq_s1_q <= link.irq_req_n;
      irq_s2_q <= irq_s1_q;
    end
  end

  // abort sources: request low or any received byte
  assign abort_req = proc_q & ((hs_en & ~irq_s2_q) | rx_valid);
  assign full_hit = (st_q == ST_RUN) & msg_valid & ~q_in_ready;

  // processing flag; after a request or byte abort only a fresh command rearms it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      proc_q <= 1'b0;
    end else if (abort_req || full_hit || op_done) begin
      proc_q <= 1'b0;
    end else if (op_start && !wait_cmd_q) begin
      proc_q <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_cmd_q <= 1'b0;
    end else if (abort_req) begin
      wait_cmd_q <= 1'b1;
    end else if (rx_valid) begin
      wait_cmd_q <= 1'b0;
    end
  end
  assign link.busy = hs_en & proc_q;

  // abort and error pulses toward the interpreter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_abort <= 1'b0;
      overflow_err <= 1'b0;
    end else begin
      op_abort <= abort_req | (full_hit & proc_q);
      overflow_err <= full_hit;
    end
  end

  // error sequence: flush, then queue the report text
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= ST_RUN;
      idx_q <= 3'h0;
    end else begin
      unique case (st_q)
        ST_RUN: begin
          if (full_hit) st_q <= ST_FLUSH;
        end
        ST_FLUSH: begin
          st_q <= ST_REPORT;
          idx_q <= 3'h0;
        end
        ST_REPORT: begin
          if (q_in_ready) begin
            idx_q <= idx_q + 3'h1;
            if (idx_q == 3'(hsp_pkg::ERR_LEN - 1)) st_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  // queue input mux; message intake stalls during the error sequence
  assign msg_ready = (st_q == ST_RUN) & q_in_ready;
  assign q_in_valid = (st_q == ST_RUN) ? msg_valid : (st_q == ST_REPORT);
  assign q_in_data = (st_q == ST_REPORT) ? hsp_pkg::ERR_TEXT[idx_q] : msg_data;

  hsp_fifo #(.W(hsp_pkg::BYTE_W), .D(TXQ_DEPTH)) u_txq (
    .core_clk(core_clk),
    .rst(rst),
    .flush(st_q == ST_FLUSH),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(q_in_data),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_out_data)
  );
  hsp_uart_tx #(.DIV(DIV)) u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(q_out_valid),
    .in_ready(q_out_ready),
    .in_data(q_out_data),
    .txd(link.txd_to_host)
  );
  hsp_uart_rx #(.DIV(DIV)) u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .rxd(link.txd_to_dev),
    .out_valid(rx_valid),
    .out_data(rx_data)
  );

  // received command bytes to the interpreter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_data <= 8'h00;
    end else begin
      cmd_valid <= rx_valid;
      if (rx_valid) cmd_data <= rx_data;
    end
  end
endmodule
`default_nettype wire

// ==== hw/hsp_host_end.sv ====
// host end: command fifo, uart, request/busy handshake toward the device
// also holds the uart leaves used by both ends; the fifo leaf sits in hw/hsp_dev_end.sv
`timescale 1ns/100ps
`default_nettype none
module hsp_host_end #(
  parameter int DIV = hsp_pkg::BAUD_DIV, // same rate as the device
  parameter int CMDQ_DEPTH = hsp_pkg::CMDQ_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  hsp_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_data,
  output logic resp_valid,
  output logic [7:0] resp_data,
  input wire logic hs_en,
  input wire logic intr_req,
  output logic busy_seen
);
  typedef enum logic [1:0] {H_IDLE, H_INTR, H_RELEASE, H_SEND} hsp_host_st_t;
  hsp_host_st_t st_q;
  logic b_s1_q, b_s2_q;
  logic intr_pend_q, rts_n_q;
  logic q_valid, q_ready, tx_ready;
  logic [7:0] q_data;

  // busy pin from the device, two-stage sync
  always_ff @(posedge core_clk) begin
    if (rst) begin
      b_s1_q <= 1'b0;
      b_s2_q <= 1'b0;
    end else begin
      b_s1_q <= link.busy;
      b_s2_q <= b_s1_q;
    end
  end
  assign busy_seen = b_s2_q;

  // interrupt wish, held until acted on
  always_ff @(posedge core_clk) begin
    if (rst) begin
      intr_pend_q <= 1'b0;
    end else if (intr_req) begin
      intr_pend_q <= 1'b1; // a fresh wish wins over the clear
    end else if (st_q == H_INTR) begin
      intr_pend_q <= 1'b0;
    end
  end

  // send gate: check busy, wait or interrupt, release, then send
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= H_IDLE;
      rts_n_q <= 1'b1;
    end else begin
      unique case (st_q)
        H_IDLE: begin
          if (q_valid) begin
            if (!hs_en || !b_s2_q) begin
              st_q <= H_SEND;
            end else if (intr_pend_q) begin
              st_q <= H_INTR;
              rts_n_q <= 1'b0;
            end
          end
        end
        H_INTR: begin
          if (!b_s2_q) begin
            st_q <= H_RELEASE;
            rts_n_q <= 1'b1;
          end
        end
        H_RELEASE: begin
          st_q <= H_SEND; // request already high again
        end
        H_SEND: begin
          if (!q_valid && tx_ready) st_q <= H_IDLE;
        end
      endcase
    end
  end
  assign link.irq_req_n = rts_n_q;
  assign q_ready = (st_q == H_SEND) & tx_ready;

  // command bytes wait here; a full queue stalls the caller
  hsp_fifo #(.W(hsp_pkg::BYTE_W), .D(CMDQ_DEPTH)) u_cmdq (
    .core_clk(core_clk),
    .rst(rst),
    .flush(1'b0),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );
  hsp_uart_tx #(.DIV(DIV)) u_tx (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(q_valid & (st_q == H_SEND)),
    .in_ready(tx_ready),
    .in_data(q_data),
    .txd(link.txd_to_dev)
  );
  // responses taken as they come, no stall possible on a uart
  hsp_uart_rx #(.DIV(DIV)) u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .rxd(link.txd_to_host),
    .out_valid(resp_valid),
    .out_data(resp_data)
  );
endmodule

// *****************************************
// uart transmitter, 8n1
// *****************************************
module hsp_uart_tx #(
  parameter int DIV = hsp_pkg::BAUD_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic txd
);
  if (DIV < 4) begin : g_chk
    $error("hsp_uart_tx divider too small");
  end
  logic [31:0] cnt_q;
  logic [3:0] bit_q;
  logic [9:0] sh_q;
  assign in_ready = (bit_q == 4'h0);
  // shifter; idle line rests high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q <= 10'h3ff;
      txd <= 1'b1;
    end else if (bit_q == 4'h0) begin
      if (in_valid) begin
        sh_q <= {1'b1, in_data, 1'b0};
        bit_q <= 4'ha;
        cnt_q <= '0;
        txd <= 1'b0;
      end
    end else if (cnt_q == 32'(DIV - 1)) begin
      cnt_q <= '0;
      bit_q <= bit_q - 4'h1;
      sh_q <= {1'b1, sh_q[9:1]};
      txd <= (bit_q == 4'h1) ? 1'b1 : sh_q[1];
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

// *****************************************
// uart receiver, 8n1, mid-bit sampling
// *****************************************
module hsp_uart_rx #(
  parameter int DIV = hsp_pkg::BAUD_DIV
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rxd,
  output logic out_valid,
  output logic [7:0] out_data
);
  // half-bit preload needs a few clocks per bit
  if (DIV < 4) begin : g_chk
    $error("hsp_uart_rx divider too small");
  end
  logic s1_q, s2_q;
  logic [31:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  // two-stage sync, idle high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= rxd;
      s2_q <= s1_q;
    end
  end
  // bit framing; a bad stop bit drops the byte
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end else begin
      out_valid <= 1'b0;
      if (bit_q == 4'h0) begin
        if (!s2_q) begin
          bit_q <= 4'ha;
          cnt_q <= 32'(DIV / 2);
        end
      end else if (cnt_q == 32'(DIV - 1)) begin
        cnt_q <= '0;
        bit_q <= bit_q - 4'h1;
        if (bit_q == 4'ha && s2_q) begin
          bit_q <= 4'h0; // glitch, not a start bit
        end else if (bit_q == 4'h1) begin
          out_valid <= s2_q;
          out_data <= sh_q;
        end else if (bit_q != 4'ha) begin
          sh_q <= {s2_q, sh_q[7:1]};
        end
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/hsp_link_assertions.sv ====
// checker for the link: handshake pair and uart framing on both lines
// assumes one clock, synchronous active-high reset, DIV clocks per bit
`timescale 1ns/100ps
`default_nettype none
module hsp_link_chk #(
  parameter int DIV = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic txd_to_host,
  input wire logic txd_to_dev,
  input wire logic irq_req_n,
  input wire logic busy
);
  localparam int BIT_MIN = DIV - 1;
  localparam int LOW_MAX = 9 * DIV + 1;
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic wait_q;
  // ****
  // helper state
  // ****
  // low run of the device line; saturates so a stuck line stays caught
  always_ff @(posedge core_clk) begin
    if (rst || txd_to_host) lo_q <= 16'h0000;
    else if (lo_q != 16'hffff) lo_q <= lo_q + 16'h0001;
  end
  // high run of the host line, the gap before each start bit
  always_ff @(posedge core_clk) begin
    if (rst || !txd_to_dev) hi_q <= 16'h0000;
    else if (hi_q != 16'hffff) hi_q <= hi_q + 16'h0001;
  end
  // busy dropped under a request; ends at the command's start bit
  always_ff @(posedge core_clk) begin
    if (rst || !txd_to_dev) wait_q <= 1'b0;
    else if ($fell(busy) && !irq_req_n) wait_q <= 1'b1;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_req_held;
    !irq_req_n && busy;
  endsequence
  sequence s_dev_start;
    $fell(txd_to_dev);
  endsequence
  a_idle_after_reset: assert property ($fell(rst) |-> txd_to_host && txd_to_dev && irq_req_n && !busy)
    else $error("link not idle after reset");
  a_req_aborts: assert property (s_req_held |-> ##[1:5] !busy)
    else $error("request did not end busy");
  a_req_holds_low: assert property (s_req_held |=> !irq_req_n)
    else $error("request released while busy");
  a_req_release: assert property ($rose(irq_req_n) |-> !busy)
    else $error("request raised while busy");
  a_quiet_in_req: assert property (!irq_req_n |-> txd_to_dev)
    else $error("host sent during request");
  a_wait_not_busy: assert property (wait_q |-> !busy)
    else $error("busy again before command");
  a_start_bit_len: assert property ($rose(txd_to_host) |-> lo_q >= BIT_MIN)
    else $error("device start bit short");
  a_frame_bound: assert property (lo_q <= LOW_MAX)
    else $error("device line low too long");
  a_stop_gap: assert property (s_dev_start |-> hi_q >= BIT_MIN)
    else $error("host stop bit short");
endmodule
`default_nettype wire

// ==== sim/host_serial_handshake_port_bench.sv ====
// bench: device end and host end joined by one link, driven from both user sides
// assumes hw/ compiled first; bit time cut to 8 clocks
`timescale 1ns/100ps
`default_nettype none
module host_serial_handshake_port_bench;
  localparam int DIV = 8;
  logic core_clk;
  logic rst = 1'b1;
  logic msg_valid = 1'b0, op_start = 1'b0, op_done = 1'b0, pwr_wr = 1'b0;
  logic h_cmd_v = 1'b0, hs_en = 1'b0, intr_req = 1'b0;
  logic [7:0] msg_data = 8'h00, pwr_wdata = 8'h00, h_cmd_d = 8'h00;
  logic msg_ready, op_abort, overflow_err, d_cmd_v, h_cmd_rdy, resp_v, h_busy_seen;
  logic [7:0] d_cmd_d, pwr_ctrl, resp_d;
  logic [7:0] rq[$];
  logic [7:0] cq[$];
  int n_mismatch = 0;
  int total_checks = 0;
  int n_abort = 0, n_ovf = 0, cyc = 0, n, k, base;
  // ****
  // ends, link and checker
  // ****
  hsp_link_if link ();
  hsp_dev_end #(.DIV(DIV)) i_hsp_dev_end (.core_clk(core_clk), .rst(rst), .link(link),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_data(msg_data), .op_start(op_start),
    .op_done(op_done), .op_abort(op_abort), .overflow_err(overflow_err), .cmd_valid(d_cmd_v),
    .cmd_data(d_cmd_d), .pwr_wr(pwr_wr), .pwr_wdata(pwr_wdata), .pwr_ctrl(pwr_ctrl));
  hsp_host_end #(.DIV(DIV)) i_hsp_host_end (.core_clk(core_clk), .rst(rst), .link(link),
    .cmd_valid(h_cmd_v), .cmd_ready(h_cmd_rdy), .cmd_data(h_cmd_d), .resp_valid(resp_v),
    .resp_data(resp_d), .hs_en(hs_en), .intr_req(intr_req), .busy_seen(h_busy_seen));
  hsp_link_chk #(.DIV(DIV)) i_hsp_link_chk (.core_clk(core_clk), .rst(rst),
    .txd_to_host(link.txd_to_host), .txd_to_dev(link.txd_to_dev),
    .irq_req_n(link.irq_req_n), .busy(link.busy));
  // ****
  // clock, monitors, tasks
  // ****
  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // collect bytes and pulses; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (resp_v === 1'b1) rq.push_back(resp_d);
    if (d_cmd_v === 1'b1) cq.push_back(d_cmd_d);
    if (op_abort === 1'b1) n_abort <= n_abort + 1;
    if (overflow_err === 1'b1) n_ovf <= n_ovf + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  // byte compare; flags go through it zero-extended
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // one-cycle pulses, entered just after a rising edge
  task automatic go_start;
    op_start <= 1'b1;
    tick(1);
    op_start <= 1'b0;
  endtask
  task automatic go_done;
    op_done <= 1'b1;
    tick(1);
    op_done <= 1'b0;
  endtask
  task automatic go_intr;
    intr_req <= 1'b1;
    tick(1);
    intr_req <= 1'b0;
  endtask
  task automatic set_pwr(input logic [7:0] d);
    pwr_wdata <= d;
    pwr_wr <= 1'b1;
    tick(1);
    pwr_wr <= 1'b0;
  endtask
  // single push into an empty command fifo
  task automatic put_cmd(input logic [7:0] d);
    h_cmd_v <= 1'b1;
    h_cmd_d <= d;
    @(negedge core_clk);
    chk1(h_cmd_rdy, 1'b1);
    tick(1);
    h_cmd_v <= 1'b0;
  endtask
  // bounded wait for command bytes at the device end
  task automatic wait_cmd(input int want);
    for (int i = 0; i < 4000 && cq.size() < want; i++) tick(1);
    chk1(cq.size() >= want, 1'b1);
  endtask
  // ****
  // tests
  // ****
  initial begin
    tick(16);
    rst <= 1'b0;
    tick(1);
    chk8(pwr_ctrl, 8'h80);
    chk1(link.txd_to_host, 1'b1);
    chk1(link.txd_to_dev, 1'b1);
    chk1(link.irq_req_n, 1'b1);
    // handshake off by default: processing never shows busy
    go_start;
    tick(3);
    chk1(link.busy, 1'b0);
    go_done;
    set_pwr(8'h00);
    tick(1);
    chk8(pwr_ctrl, 8'h00);
    // a command queued while busy is held back
    hs_en <= 1'b1;
    go_start;
    tick(2);
    chk1(link.busy, 1'b1);
    base = cq.size();
    put_cmd(8'h41);
    tick(300);
    chk1(cq.size() == base, 1'b1);
    chk1(h_busy_seen, 1'b1);
    // interrupt: busy drops, no restart, then the command crosses
    go_intr;
    tick(20);
    chk1(link.busy, 1'b0);
    chk1(n_abort == 1, 1'b1);
    chk1(h_busy_seen, 1'b0);
    go_start;
    tick(3);
    chk1(link.busy, 1'b0);
    wait_cmd(base + 1);
    chk8(cq[base], 8'h41);
    tick(2);
    go_start;
    tick(2);
    chk1(link.busy, 1'b1);
    go_done;
    tick(2);
    chk1(link.busy, 1'b0);
    // command fifo filled until refused, then drained in order
    hs_en <= 1'b0;
    base = cq.size();
    n = 0;
    h_cmd_d <= 8'h00;
    h_cmd_v <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(negedge core_clk);
      if (h_cmd_rdy !== 1'b1) break;
      tick(1);
      n++;
      h_cmd_d <= n[7:0];
    end
    tick(1);
    h_cmd_v <= 1'b0;
    chk1(n == 32 || n == 33, 1'b1);
    wait_cmd(base + n);
    for (k = 0; k < n; k++) chk8(cq[base + k], k[7:0]);
    // a byte received while processing aborts like a request
    go_start;
    tick(2);
    chk1(link.busy, 1'b1);
    put_cmd(8'h55);
    wait_cmd(base + n + 1);
    tick(2);
    chk1(link.busy, 1'b0);
    chk1(n_abort == 2, 1'b1);
    chk8(cq[base + n], 8'h55);
    go_start;
    tick(2);
    chk1(link.busy, 1'b0);
    // the next byte rearms processing
    put_cmd(8'h56);
    wait_cmd(base + n + 2);
    // flood the transmit queue while processing until it refuses
    go_start;
    n = 0;
    msg_data <= 8'h00;
    msg_valid <= 1'b1;
    for (k = 0; k < 900; k++) begin
      @(negedge core_clk);
      if (msg_ready !== 1'b1) break;
      tick(1);
      n++;
      msg_data <= n[7:0];
    end
    base = n - rq.size();
    tick(1);
    msg_valid <= 1'b0;
    tick(2);
    chk1(msg_ready, 1'b0);
    chk1(base >= 512 && base <= 514, 1'b1);
    tick(10);
    chk1(n_ovf == 1, 1'b1);
    chk1(n_abort == 3, 1'b1);
    chk1(link.busy, 1'b0);
    // intake resumes once the report is queued
    msg_data <= 8'h5a;
    msg_valid <= 1'b1;
    @(negedge core_clk);
    chk1(msg_ready, 1'b1);
    tick(1);
    msg_valid <= 1'b0;
    tick(800);
    for (k = 0; k < 5; k++) chk8(rq[rq.size() - 6 + k], hsp_pkg::ERR_TEXT[k]);
    chk8(rq[rq.size() - 1], 8'h5a);
    for (k = 0; k < 4; k++) chk8(rq[k], k[7:0]);
    final_report();
  end
endmodule
`default_nettype wire
